// ### src/xlc_pkg.sv
package xlc_pkg;
  localparam int SEL_W = 6;
  localparam int PRI_IN_N = 32;
  localparam int PRI_OUT_N = 41;
  localparam int SEC_IN_N = 26;
  localparam int SEC_OUT_N = 16;
  localparam int CMB_N = 2;
  localparam int CMB_IN_N = 4;
  localparam int TERM_N = 4;
  localparam int CMP_N = 4;
  localparam int TRIG_N = 3;
  // fixed wiring of internal sources into the crossbars
  localparam int IDX_CMP_A = 10;
  localparam int IDX_TRIG0 = 18;
  localparam int IDX_TRIG1 = 20;
  localparam int IDX_TRIG2 = 22;
  localparam int IDX_CMB0 = 28;
  localparam int IDX_CMB1 = 29;
  // primary outputs with a fixed consumer
  localparam int OUT_SAMPLE0 = 16;
  localparam int OUT_FAULT_TWO = 31;
  // secondary outputs feeding each combiner
  localparam int CMB0_FIRST_OUT = 0;
  localparam int CMB1_FIRST_OUT = 4;
  localparam int CMB1_USED_IN = 3;
  // product-term input control encodings
  localparam logic [1:0] CTL_ZERO = 2'h0;
  localparam logic [1:0] CTL_TRUE = 2'h1;
  localparam logic [1:0] CTL_INV = 2'h2;
  localparam logic [1:0] CTL_ONE = 2'h3;
  localparam int SELS_PER_REG = 2;
  localparam int TERMS_PER_REG = 2;

  // two select fields per select register
  typedef struct packed {
    logic [SEL_W-1:0] sel_hi;
    logic [SEL_W-1:0] sel_lo;
  } xlc_sel_reg_t;

  // controls of one product term, input d in the high bits
  typedef struct packed {
    logic [1:0] d;
    logic [1:0] c;
    logic [1:0] b;
    logic [1:0] a;
  } xlc_term_ctl_t;

  // one term control register holds two product terms
  typedef struct packed {
    xlc_term_ctl_t term_hi;
    xlc_term_ctl_t term_lo;
  } xlc_term_reg_t;
endpackage

// ### src/xlc_routing.sv
`timescale 1ns/100ps
// Contract
// - secondary output forwards input at select value
// - two secondary select fields per register
// - comparators A-D are inputs 10-13
// - secondary outputs 0-3, 4-6 feed combiners
// - any secondary input reaches any combiner input except combiner one input d, tied to zero
// - control 01 passes the true input
// - control 11 forces contribution to one
// - four terms, two per control register
// - combiner zero is primary input 28
// - output 31 in register 15 drives fault two
// - trigger pulses are inputs 18, 20, 22
// - combiner one is primary input 29
// - outputs 16-19 sample comparators, registers 8-9
// - many outputs may share one input
// - any primary input reaches any output
module xlc_routing (
  input wire logic clk,
  input wire logic rst,
  input wire logic [xlc_pkg::PRI_IN_N-1:0] primary_ext_in,
  input wire logic [xlc_pkg::SEC_IN_N-1:0] secondary_ext_in,
  input wire logic [xlc_pkg::CMP_N-1:0] comparator_result,
  input wire logic [xlc_pkg::TRIG_N-1:0] trigger_pulse,
  input wire xlc_pkg::xlc_sel_reg_t primary_select_reg [(xlc_pkg::PRI_OUT_N+1)/2],
  input wire xlc_pkg::xlc_sel_reg_t secondary_select_reg [xlc_pkg::SEC_OUT_N/2],
  input wire xlc_pkg::xlc_term_reg_t combiner_term01_control [xlc_pkg::CMB_N],
  input wire xlc_pkg::xlc_term_reg_t combiner_term23_control [xlc_pkg::CMB_N],
  output logic [xlc_pkg::PRI_OUT_N-1:0] primary_out,
  output logic [xlc_pkg::SEC_OUT_N-1:0] secondary_out,
  output logic [xlc_pkg::CMB_N-1:0] combiner_out,
  output logic modulator_fault_two,
  output logic [xlc_pkg::CMP_N-1:0] comparator_sample
);
  import xlc_pkg::*;

  logic [PRI_IN_N-1:0] pri_in;
  logic [SEC_IN_N-1:0] sec_in;
  logic [SEL_W-1:0] pri_sel [PRI_OUT_N];
  logic [SEL_W-1:0] sec_sel [SEC_OUT_N];
  xlc_term_ctl_t term_ctl [CMB_N][TERM_N];
  logic [CMB_IN_N-1:0] cmb_in [CMB_N];

  // contribution of one input to a product term
  function automatic logic term_bit(input logic [1:0] ctl, input logic x);
    case (ctl)
      CTL_TRUE: term_bit = x;
      CTL_INV: term_bit = ~x;
      CTL_ONE: term_bit = 1'b1;
      default: term_bit = 1'b0;
    endcase
  endfunction

  // out-of-range select reads as zero
  function automatic logic pick_pri(input logic [PRI_IN_N-1:0] v, input logic [SEL_W-1:0] s);
    pick_pri = (int'(s) < PRI_IN_N) ? v[s[4:0]] : 1'b0;
  endfunction

  function automatic logic pick_sec(input logic [SEC_IN_N-1:0] v, input logic [SEL_W-1:0] s);
    pick_sec = (int'(s) < SEC_IN_N) ? v[s[4:0]] : 1'b0;
  endfunction

  // internal sources overlay the external inputs
  always_comb begin
    pri_in = primary_ext_in;
    sec_in = secondary_ext_in;
    for (int i = 0; i < CMP_N; i++) begin
      pri_in[IDX_CMP_A+i] = comparator_result[i];
      sec_in[IDX_CMP_A+i] = comparator_result[i];
    end
    pri_in[IDX_TRIG0] = trigger_pulse[0];
    pri_in[IDX_TRIG1] = trigger_pulse[1];
    pri_in[IDX_TRIG2] = trigger_pulse[2];
    sec_in[IDX_TRIG0] = trigger_pulse[0];
    sec_in[IDX_TRIG1] = trigger_pulse[1];
    sec_in[IDX_TRIG2] = trigger_pulse[2];
    pri_in[IDX_CMB0] = combiner_out[0];
    pri_in[IDX_CMB1] = combiner_out[1];
  end

  always_comb begin
    for (int o = 0; o < SEC_OUT_N; o++) begin
      sec_sel[o] = (o % SELS_PER_REG == 0) ? secondary_select_reg[o/SELS_PER_REG].sel_lo
                                           : secondary_select_reg[o/SELS_PER_REG].sel_hi;
    end
    for (int o = 0; o < PRI_OUT_N; o++) begin
      pri_sel[o] = (o % SELS_PER_REG == 0) ? primary_select_reg[o/SELS_PER_REG].sel_lo
                                           : primary_select_reg[o/SELS_PER_REG].sel_hi;
    end
  end

  always_comb begin
    for (int o = 0; o < SEC_OUT_N; o++) begin
      secondary_out[o] = pick_sec(sec_in, sec_sel[o]);
    end
  end

  always_comb begin
    for (int k = 0; k < CMB_IN_N; k++) begin
      cmb_in[0][k] = secondary_out[CMB0_FIRST_OUT+k];
      cmb_in[1][k] = (k < CMB1_USED_IN) ? secondary_out[CMB1_FIRST_OUT+k] : 1'b0;
    end
  end

  always_comb begin
    for (int c = 0; c < CMB_N; c++) begin
      term_ctl[c][0] = combiner_term01_control[c].term_lo;
      term_ctl[c][1] = combiner_term01_control[c].term_hi;
      term_ctl[c][2] = combiner_term23_control[c].term_lo;
      term_ctl[c][3] = combiner_term23_control[c].term_hi;
    end
  end

  always_comb begin
    for (int c = 0; c < CMB_N; c++) begin
      combiner_out[c] = 1'b0;
      for (int t = 0; t < TERM_N; t++) begin
        combiner_out[c] = combiner_out[c] |
          (term_bit(term_ctl[c][t].a, cmb_in[c][0]) & term_bit(term_ctl[c][t].b, cmb_in[c][1]) &
           term_bit(term_ctl[c][t].c, cmb_in[c][2]) & term_bit(term_ctl[c][t].d, cmb_in[c][3]));
      end
    end
  end

  always_comb begin
    for (int o = 0; o < PRI_OUT_N; o++) begin
      primary_out[o] = pick_pri(pri_in, pri_sel[o]);
    end
  end

  assign modulator_fault_two = primary_out[OUT_FAULT_TWO];
  assign comparator_sample = primary_out[OUT_SAMPLE0 +: CMP_N];
endmodule

// ### verification/xlc_routing_assertions.sv
`timescale 1ns/100ps
module xlc_routing_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic [xlc_pkg::CMP_N-1:0] comparator_result,
  input wire logic [xlc_pkg::TRIG_N-1:0] trigger_pulse,
  input wire xlc_pkg::xlc_sel_reg_t primary_select_reg [(xlc_pkg::PRI_OUT_N+1)/2],
  input wire xlc_pkg::xlc_sel_reg_t secondary_select_reg [xlc_pkg::SEC_OUT_N/2],
  input wire logic [xlc_pkg::PRI_OUT_N-1:0] primary_out,
  input wire logic [xlc_pkg::SEC_OUT_N-1:0] secondary_out,
  input wire logic [xlc_pkg::CMB_N-1:0] combiner_out,
  input wire logic modulator_fault_two,
  input wire logic [xlc_pkg::CMP_N-1:0] comparator_sample
);
  import xlc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  fault_pin_a: assert property (modulator_fault_two == primary_out[31]) else $error("fault pin");
  sample_pin_a: assert property (comparator_sample == primary_out[19:16]) else $error("sample pins");
  cmb0_route_a: assert property (primary_select_reg[15].sel_hi == 6'h1C
    |-> modulator_fault_two == combiner_out[0]) else $error("combiner zero route");
  cmb1_fan_a: assert property (primary_select_reg[8] == {6'h1D, 6'h1D}
    |-> comparator_sample[1:0] == {2{combiner_out[1]}}) else $error("combiner one fan");
  sec_sel0_a: assert property (secondary_select_reg[0].sel_lo == 6'h0A
    |-> secondary_out[0] == comparator_result[0]) else $error("secondary out 0");
  sec_sel3_a: assert property (secondary_select_reg[1].sel_hi == 6'h0D
    |-> secondary_out[3] == comparator_result[3]) else $error("secondary out 3");
  sec_trig_a: assert property (secondary_select_reg[2].sel_lo == 6'h12
    |-> secondary_out[4] == trigger_pulse[0]) else $error("trigger route");
  sec_now_a: assert property (secondary_select_reg[0].sel_lo == 6'h0A && $changed(comparator_result[0])
    |-> $changed(secondary_out[0])) else $error("route lags");
endmodule
bind xlc_routing xlc_routing_assertions u_xlc_routing_assertions (.clk, .rst, .comparator_result,
  .trigger_pulse, .primary_select_reg, .secondary_select_reg, .primary_out, .secondary_out,
  .combiner_out, .modulator_fault_two, .comparator_sample);

// ### verification/xlc_partner.sv
`timescale 1ns/100ps
module xlc_partner (
  input wire logic clk,
  input wire logic [6:0] stim,
  output logic [xlc_pkg::CMP_N-1:0] comparator_result,
  output logic [xlc_pkg::TRIG_N-1:0] trigger_pulse
);
  import xlc_pkg::*;
  always @(posedge clk) {trigger_pulse, comparator_result} <= stim;
endmodule

// ### verification/tb_xlc_routing.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; $display("wrong value %s %h %h", n, e, s); end end
module tb_xlc_routing;
  import xlc_pkg::*;
  logic clk = 0, rst = 1, fault;
  logic [6:0] stim = 7'h00;
  logic [PRI_IN_N-1:0] pin = '0;
  logic [SEC_IN_N-1:0] sin = '0;
  logic [3:0] cmp, samp;
  logic [2:0] trg;
  logic [PRI_OUT_N-1:0] pout;
  logic [SEC_OUT_N-1:0] sout;
  logic [1:0] cout;
  xlc_sel_reg_t ps [(PRI_OUT_N+1)/2] = '{default: '0};
  xlc_sel_reg_t ss [SEC_OUT_N/2] = '{default: '0};
  xlc_term_reg_t t01 [CMB_N] = '{default: '0};
  xlc_term_reg_t t23 [CMB_N] = '{default: '0};
  int err_total = 0, n_checks = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  xlc_partner u_xlc_partner (.clk(clk), .stim(stim), .comparator_result(cmp), .trigger_pulse(trg));
  xlc_routing u_xlc_routing (.clk(clk), .rst(rst), .primary_ext_in(pin), .secondary_ext_in(sin),
    .comparator_result(cmp), .trigger_pulse(trg), .primary_select_reg(ps), .secondary_select_reg(ss),
    .combiner_term01_control(t01), .combiner_term23_control(t23), .primary_out(pout),
    .secondary_out(sout), .combiner_out(cout), .modulator_fault_two(fault), .comparator_sample(samp));
  task put(input logic [6:0] v);
    @(negedge clk) stim = v;
    @(negedge clk);
  endtask
  task t_codes;
    ss[0].sel_lo = 6'h0A;
    for (int k = 0; k < 8; k++) begin
      t01[0].term_lo = {CTL_ONE, CTL_ONE, CTL_ONE, 2'(k >> 1)};
      put(7'(k & 1));
      `CHK("code", k[2] ? k[1] | ~k[0] : k[1] & k[0], cout[0])
    end
  endtask
  task t_fault;
    ss[0] = {6'h0B, 6'h0A};
    ss[1] = {6'h0D, 6'h0C};
    t01[0] = {{CTL_ONE, CTL_TRUE, CTL_ONE, CTL_TRUE}, {CTL_ONE, CTL_ONE, CTL_TRUE, CTL_TRUE}};
    t23[0] = {{CTL_TRUE, CTL_ONE, CTL_ONE, CTL_ONE}, {CTL_ONE, CTL_TRUE, CTL_TRUE, CTL_ONE}};
    ps[15].sel_hi = 6'h1C;
    for (int v = 0; v < 16; v++) begin
      put(7'(v));
      `CHK("fault", 1'((v & 8) || (v & 3) == 3 || (v & 5) == 5 || (v & 6) == 6), fault)
    end
  endtask
  task t_sample;
    ss[2] = {6'h14, 6'h12};
    ss[3].sel_lo = 6'h16;
    t01[1] = {{CTL_ONE, CTL_ONE, CTL_TRUE, CTL_ONE}, {CTL_ONE, CTL_ONE, CTL_ONE, CTL_TRUE}};
    t23[1] = {8'h00, CTL_ONE, CTL_TRUE, CTL_ONE, CTL_ONE};
    ps[8] = {6'h1D, 6'h1D};
    ps[9] = {6'h1D, 6'h1D};
    for (int t = 0; t < 8; t++) begin
      put(7'(t << 4));
      `CHK("sample", {4{t != 0}}, samp)
    end
  endtask
  task t_any;
    ps[0].sel_lo = 6'h05;
    ss[3].sel_hi = 6'h19;
    for (int b = 0; b < 2; b++) begin
      @(negedge clk) {pin[5], sin[25]} = {2{1'(b)}};
      #1 `CHK("primary", 1'(b), pout[0])
      `CHK("secondary", 1'(b), sout[7])
    end
    @(negedge clk) begin
      pin = '1;
      ps[0].sel_lo = 6'h20;
    end
    #1 `CHK("refused", 1'b0, pout[0])
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_codes();
    t_fault();
    t_sample();
    t_any();
    summarize();
  end
endmodule
